// ---- memdec_pkg.sv ----
// Purpose: types shared by the memory decoder and its testbench
// Assumes: onchip_mem_defines.svh on the include path
// Notes:   request and response carriers for the cpu side
package memdec_pkg;
  `include "onchip_mem_defines.svh"

  typedef enum logic [2:0] {
    MODE_PROM        = 3'b000,
    MODE_EXP_MIN_EXT = 3'b001,
    MODE_EXP_MIN_ROM = 3'b010,
    MODE_EXP_MAX_EXT = 3'b011,
    MODE_EXP_MAX_ROM = 3'b100,
    MODE_RSVD_5      = 3'b101,
    MODE_RSVD_6      = 3'b110,
    MODE_SINGLE      = 3'b111
  } op_mode_t;

  typedef enum logic {
    ACC_IDLE = 1'b0,
    ACC_DONE = 1'b1
  } acc_state_t;

  typedef struct packed {
    logic                   valid;
    logic                   write;
    logic                   fetch;
    logic [`CPU_BE_W-1:0]   be;
    logic [`CPU_AW-1:0]     addr;
    logic [`CPU_DW-1:0]     wdata;
  } cpu_req_t;

  typedef struct packed {
    logic                   done;
    logic                   addr_error;
    logic                   ext_access;
    logic                   ram_hit;
    logic                   rom_hit;
    logic [`CPU_AW-1:0]     addr;
    logic [`CPU_DW-1:0]     rdata;
  } cpu_resp_t;
endpackage : memdec_pkg

// ---- memdec_props.sv ----
// Purpose: port-level properties of the memory decoder
// Assumes: one clock domain, reset active low
// Notes:   bound to every decoder instance
`timescale 1ns/10ps
`include "onchip_mem_defines.svh"
module memdec_props
  import memdec_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0
)(
  // clock and reset
  input wire logic                  core_clk_i,
  input wire logic                  reset_n_i,
  // programming pins
  input wire logic                  prog_ce_n_i,
  input wire logic                  prog_oe_n_i,
  input wire logic                  prog_data_lines_oe_o,
  // ram control
  input wire logic                  ram_ctl_wr_i,
  input wire logic [7:0]            ram_ctl_wdata_i,
  input wire logic [7:0]            ram_ctl_o,
  // cpu side and status
  input wire memdec_pkg::cpu_req_t  cpu_req_i,
  input wire logic                  cpu_ready_o,
  input wire memdec_pkg::cpu_resp_t cpu_resp_o,
  input wire logic                  mode_valid_o,
  input wire memdec_pkg::op_mode_t  op_mode_o,
  input wire logic                  rom_enabled_o,
  input wire logic                  prom_mode_o
);
  import memdec_pkg::*;
  localparam int ROM_B = LARGE_VARIANT ? `ROM_BYTES_LARGE : `ROM_BYTES_SMALL;
  wire logic win = cpu_resp_o.addr >= `RAM_WIN_LO && cpu_resp_o.addr <= `RAM_WIN_HI;
  wire logic en  = ram_ctl_o[`RAM_CTL_EN_BIT];
  wire logic dn  = cpu_resp_o.done;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_take;
    cpu_ready_o && cpu_req_i.valid;
  endsequence
  sequence s_answer;
    !cpu_ready_o && !dn ##1 cpu_ready_o && dn;
  endsequence
  a_two_state_access:
    assert property (s_take |=> s_answer) else $error("cpu answer not in two states");
  a_ram_window_hit:
    assert property (dn && win && en |-> cpu_resp_o.ram_hit && !cpu_resp_o.addr_error)
    else $error("ram window not served by ram");
  a_window_goes_ext:
    assert property (dn && win && !en && op_mode_o != MODE_SINGLE |->
      cpu_resp_o.ext_access && !cpu_resp_o.ram_hit) else $error("window not external");
  a_window_addr_error:
    assert property (dn && win && !en && op_mode_o == MODE_SINGLE |->
      cpu_resp_o.addr_error && !cpu_resp_o.ram_hit) else $error("no address error");
  a_ctl_reset_value:
    assert property ($rose(mode_valid_o) |-> ram_ctl_o == 8'hff) else $error("ctl reset");
  a_ctl_write_bit:
    assert property (mode_valid_o && !prom_mode_o && ram_ctl_wr_i |=>
      en == $past(ram_ctl_wdata_i[7]) && ram_ctl_o[6:0] == 7'h7f) else $error("ctl write");
  a_rom_range_hit:
    assert property (dn && !win && rom_enabled_o |-> cpu_resp_o.rom_hit ==
      (cpu_resp_o.addr < ROM_B) && cpu_resp_o.ext_access == !cpu_resp_o.rom_hit)
    else $error("rom range decode");
  a_mode_held_fixed:
    assert property (mode_valid_o && $past(mode_valid_o) |->
      $stable(op_mode_o) && $stable(rom_enabled_o)) else $error("mode changed in run");
  a_rom_by_mode:
    assert property (mode_valid_o && !prom_mode_o |-> rom_enabled_o ==
      (op_mode_o inside {MODE_EXP_MIN_ROM, MODE_EXP_MAX_ROM, MODE_SINGLE}))
    else $error("rom enable by mode");
  a_prom_halts_cpu:
    assert property (prom_mode_o |-> !cpu_ready_o && !dn) else $error("cpu runs in prom");
  a_verify_drives:
    assert property ((prom_mode_o && prog_ce_n_i && !prog_oe_n_i) [*5] |->
      prog_data_lines_oe_o) else $error("verify not driving");
  a_inhibit_floats:
    assert property ((prog_ce_n_i && prog_oe_n_i) [*5] |-> !prog_data_lines_oe_o)
    else $error("inhibit still driving");
endmodule : memdec_props

bind onchip_memory_decode_prom_port memdec_props #(.LARGE_VARIANT(LARGE_VARIANT)) u_props (
  .core_clk_i           (core_clk_i),
  .reset_n_i            (reset_n_i),
  .prog_ce_n_i          (prog_ce_n_i),
  .prog_oe_n_i          (prog_oe_n_i),
  .prog_data_lines_oe_o (prog_data_lines_oe_o),
  .ram_ctl_wr_i         (ram_ctl_wr_i),
  .ram_ctl_wdata_i      (ram_ctl_wdata_i),
  .ram_ctl_o            (ram_ctl_o),
  .cpu_req_i            (cpu_req_i),
  .cpu_ready_o          (cpu_ready_o),
  .cpu_resp_o           (cpu_resp_o),
  .mode_valid_o         (mode_valid_o),
  .op_mode_o            (op_mode_o),
  .rom_enabled_o        (rom_enabled_o),
  .prom_mode_o          (prom_mode_o)
);

// ---- onchip_mem_defines.svh ----
// Purpose: named constants for the on-chip memory decoder and programming port
// Assumes: included by bare name wherever a constant is needed
// Notes:   definitions only
`ifndef ONCHIP_MEM_DEFINES_SVH
`define ONCHIP_MEM_DEFINES_SVH

// ram window, byte addresses inclusive
`define RAM_WIN_LO       16'hf680
`define RAM_WIN_HI       16'hfe7f
// ram control register layout
`define RAM_CTL_EN_BIT   7
`define RAM_CTL_EN_RST   1'b1
`define RAM_CTL_RSVD     7'h7f
// rom sizes in bytes
`define ROM_BYTES_SMALL  32768
`define ROM_BYTES_LARGE  63488
// programming address widths per variant
`define PROG_AW_SMALL    15
`define PROG_AW_LARGE    17
// cpu data path and prom programming data width
`define CPU_AW           16
`define CPU_DW           16
`define CPU_BE_W         2
`define PROG_DW          8
// pin synchroniser fill time before straps are captured
`define SYNC_FILL        2'h2
// value read from an absent prom byte, one whose address lies beyond the rom size
`define PROM_BLANK       8'hff

`endif

// ---- onchip_memory_decode_prom_port.sv ----
// Purpose: on-chip ram/rom address decode and byte-wide prom programming port
// Assumes: straps and programming pins are asynchronous; cpu side is on core_clk_i
// Notes:   straps are captured once the pin synchronisers have filled after reset
`timescale 1ns/10ps
`include "onchip_mem_defines.svh"

// Contract
// - ram enabled: window served by on-chip ram
// - expanded modes, ram disabled: window goes external
// - single-chip, ram disabled: window access is error
// - enable bit 7, resets to one, standby-safe
// - rom uses 16-bit path, two-state access
// - rom spans 32 or 62 kbytes
// - rom enable fixed from straps at reset exit
// - modes 1 and 3 disable rom
// - modes 2, 4, 7 enable rom
// - programming mode halts normal cpu functions
// - ce low, oe high writes addressed byte
// - ce high oe low verifies, both high floats
module onchip_memory_decode_prom_port
  import memdec_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b0,
  parameter int PROG_AW       = `PROG_AW_SMALL
)(
  // clock and reset
  input  wire logic                    core_clk_i,
  input  wire logic                    reset_n_i,
  // mode straps and programming-mode select pins
  input  wire logic                    mode_pin_2_i,
  input  wire logic                    mode_pin_1_i,
  input  wire logic                    mode_pin_0_i,
  input  wire logic                    standby_input_n_i,
  input  wire logic                    port6_bit1_i,
  input  wire logic                    port6_bit0_i,
  // prom programming port
  input  wire logic                    prog_ce_n_i,
  input  wire logic                    prog_oe_n_i,
  input  wire logic [PROG_AW-1:0]      prog_address_lines_i,
  input  wire logic [`PROG_DW-1:0]     prog_data_lines_i,
  output logic      [`PROG_DW-1:0]     prog_data_lines_o,
  output logic                         prog_data_lines_oe_o,
  // ram control register
  input  wire logic                    ram_ctl_wr_i,
  input  wire logic [7:0]              ram_ctl_wdata_i,
  output logic      [7:0]              ram_ctl_o,
  // cpu access
  input  wire memdec_pkg::cpu_req_t    cpu_req_i,
  output logic                         cpu_ready_o,
  output memdec_pkg::cpu_resp_t        cpu_resp_o,
  // status
  output logic                         mode_valid_o,
  output memdec_pkg::op_mode_t         op_mode_o,
  output logic                         rom_enabled_o,
  output logic                         prom_mode_o
);
  import memdec_pkg::*;

  localparam int ROM_BYTES = LARGE_VARIANT ? `ROM_BYTES_LARGE : `ROM_BYTES_SMALL;
  localparam int ROM_WORDS = ROM_BYTES / 2;
  localparam int ROM_AW    = $clog2(ROM_WORDS);
  localparam int RAM_WORDS = (int'(`RAM_WIN_HI) - int'(`RAM_WIN_LO) + 1) / 2;
  localparam int RAM_AW    = $clog2(RAM_WORDS);
  localparam int SW        = 8 + PROG_AW + `PROG_DW;

  if (PROG_AW != (LARGE_VARIANT ? `PROG_AW_LARGE : `PROG_AW_SMALL))
  begin : g_bad_aw
    $error("prog address width does not match variant");
  end

  // pin synchroniser
  logic [SW-1:0]  pin_raw;
  logic [SW-1:0]  pin_meta_q;
  logic [SW-1:0]  pin_sync_q;

  assign pin_raw = {mode_pin_2_i, mode_pin_1_i, mode_pin_0_i, standby_input_n_i,
                    port6_bit1_i, port6_bit0_i, prog_ce_n_i, prog_oe_n_i,
                    prog_address_lines_i, prog_data_lines_i};

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end
    else
    begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  wire [2:0]          mode_s   = pin_sync_q[SW-1 -: 3];
  wire                standby_input_n_n_s = pin_sync_q[SW-4];
  wire                p61_s    = pin_sync_q[SW-5];
  wire                p60_s    = pin_sync_q[SW-6];
  wire                ce_n_s   = pin_sync_q[SW-7];
  wire                oe_n_s   = pin_sync_q[SW-8];
  wire [PROG_AW-1:0]  paddr_s  = pin_sync_q[`PROG_DW +: PROG_AW];
  wire [7:0]          pdata_s  = pin_sync_q[`PROG_DW-1:0];

  // strap capture after reset release
  logic [1:0]  fill_cnt_q;
  logic        mode_valid_q;
  op_mode_t    op_mode_q;
  logic        rom_en_q;
  logic        prom_q;

  wire capture = !mode_valid_q && (fill_cnt_q == `SYNC_FILL);
  wire prom_pattern = (mode_s == MODE_PROM) && !standby_input_n_n_s && p61_s && p60_s;
  wire rom_en_pattern = (mode_s == MODE_EXP_MIN_ROM) || (mode_s == MODE_EXP_MAX_ROM)
                        || (mode_s == MODE_SINGLE);

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fill_cnt_q   <= '0;
      mode_valid_q <= 1'b0;
      op_mode_q    <= MODE_SINGLE;
      rom_en_q     <= 1'b0;
      prom_q       <= 1'b0;
    end
    else if (capture)
    begin
      // held for the whole operating mode, only a new reset recaptures
      mode_valid_q <= 1'b1;
      op_mode_q    <= op_mode_t'(mode_s);
      rom_en_q     <= rom_en_pattern;
      prom_q       <= prom_pattern;
    end
    else if (!mode_valid_q)
    begin
      fill_cnt_q <= fill_cnt_q + 2'h1;
    end
  end

  // normal operation only outside programming mode
  wire normal_run = mode_valid_q && !prom_q;
  wire single     = (op_mode_q == MODE_SINGLE);

  // ram control register; reset only, standby leaves it alone
  logic ram_en_q;

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ram_en_q <= `RAM_CTL_EN_RST;
    end
    else if (ram_ctl_wr_i && normal_run)
    begin
      ram_en_q <= ram_ctl_wdata_i[`RAM_CTL_EN_BIT];
    end
  end

  // cpu request decode
  wire [`CPU_AW-1:0] req_addr = cpu_req_i.addr;
  wire [`CPU_AW-1:0] ram_off  = req_addr - `RAM_WIN_LO;
  wire in_ram_win = (req_addr >= `RAM_WIN_LO) && (req_addr <= `RAM_WIN_HI);
  wire in_rom     = rom_en_q && ({1'b0, req_addr} < 17'(ROM_BYTES));
  wire sel_ram    = in_ram_win && ram_en_q;
  wire sel_err    = in_ram_win && !ram_en_q && single;
  wire sel_rom    = !in_ram_win && in_rom;
  wire sel_ext    = !sel_ram && !sel_err && !sel_rom;

  acc_state_t  acc_q;
  logic        ready_q;
  cpu_resp_t   resp_q;
  logic [3:0]  sel_q;

  wire take = normal_run && ready_q && cpu_req_i.valid;

  // ram instance
  wire [`CPU_DW-1:0] ram_rdata;

  word_store #(
    .DW    (`CPU_DW),
    .DEPTH (RAM_WORDS),
    .AW    (RAM_AW)
  ) u_ram (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .en_i       (take && sel_ram),
    .we_i       (cpu_req_i.write),
    .be_i       (cpu_req_i.be),
    .addr_i     (ram_off[RAM_AW:1]),
    .wdata_i    (cpu_req_i.wdata),
    .rdata_o    (ram_rdata)
  );

  // rom port shared between cpu and programming port
  wire ce_fall;
  logic ce_n_prev_q;
  assign ce_fall = ce_n_prev_q && !ce_n_s;
  wire prog_in_range = ({{(32-PROG_AW){1'b0}}, paddr_s} < ROM_BYTES);
  wire prog_write = prom_q && ce_fall && oe_n_s && prog_in_range;
  wire prog_verify = prom_q && ce_n_s && !oe_n_s;

  wire                rom_en_port = prom_q ? 1'b1 : (take && sel_rom);
  wire [ROM_AW-1:0]   rom_addr    = prom_q ? paddr_s[ROM_AW:1] : req_addr[ROM_AW:1];
  wire [1:0]          rom_be      = paddr_s[0] ? 2'b10 : 2'b01;
  wire [`CPU_DW-1:0]  rom_rdata;

  word_store #(
    .DW    (`CPU_DW),
    .DEPTH (ROM_WORDS),
    .AW    (ROM_AW)
  ) u_rom (
    .core_clk_i (core_clk_i),
    .reset_n_i  (reset_n_i),
    .en_i       (rom_en_port),
    .we_i       (prog_write),
    .be_i       (rom_be),
    .addr_i     (rom_addr),
    .wdata_i    ({pdata_s, pdata_s}),
    .rdata_o    (rom_rdata)
  );

  // two-state access: taken on one edge, answered on the next
  wire [`CPU_DW-1:0] done_rdata = sel_q[0] ? ram_rdata :
                                  sel_q[1] ? rom_rdata : '0;

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      acc_q   <= ACC_IDLE;
      ready_q <= 1'b0;
      resp_q  <= '0;
      sel_q   <= '0;
    end
    else
    begin
      case (acc_q)
        ACC_IDLE:
        begin
          resp_q.done       <= 1'b0;
          resp_q.addr_error <= 1'b0;
          resp_q.ext_access <= 1'b0;
          ready_q           <= normal_run;
          if (take)
          begin
            acc_q         <= ACC_DONE;
            ready_q       <= 1'b0;
            sel_q         <= {sel_err, sel_ext, sel_rom, sel_ram};
            resp_q.addr   <= req_addr;
          end
        end
        ACC_DONE:
        begin
          acc_q             <= ACC_IDLE;
          ready_q           <= normal_run;
          resp_q.done       <= 1'b1;
          resp_q.ram_hit    <= sel_q[0];
          resp_q.rom_hit    <= sel_q[1];
          resp_q.ext_access <= sel_q[2];
          resp_q.addr_error <= sel_q[3];
          resp_q.rdata      <= done_rdata;
        end
        default:
        begin
          acc_q   <= ACC_IDLE;
          ready_q <= 1'b0;
        end
      endcase
    end
  end

  // programming port data lines
  logic [7:0] pdata_out_q;
  logic       pdata_oe_q;
  wire  [7:0] rom_byte = paddr_s[0] ? rom_rdata[15:8] : rom_rdata[7:0];

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ce_n_prev_q <= 1'b0;
      pdata_out_q <= '0;
      pdata_oe_q  <= 1'b0;
    end
    else
    begin
      ce_n_prev_q <= ce_n_s;
      pdata_oe_q  <= prog_verify;
      pdata_out_q <= prog_in_range ? rom_byte : `PROM_BLANK;
    end
  end

  assign prog_data_lines_o    = pdata_out_q;
  assign prog_data_lines_oe_o = pdata_oe_q;
  assign ram_ctl_o            = {ram_en_q, `RAM_CTL_RSVD};
  assign cpu_ready_o          = ready_q;
  assign cpu_resp_o           = resp_q;
  assign mode_valid_o         = mode_valid_q;
  assign op_mode_o            = op_mode_q;
  assign rom_enabled_o        = rom_en_q;
  assign prom_mode_o          = prom_q;
endmodule : onchip_memory_decode_prom_port

// ---- prom_writer.sv ----
// Purpose: behavioural external prom writer
// Assumes: pins change just after a rising edge
// Notes:   data lines show inverse of last byte when not writing
`timescale 1ns/10ps
module prom_writer #(
  parameter int AW = 15
)(
  // clock
  input  wire logic          core_clk_i,
  // programming pins
  input  wire logic [7:0]    data_i,
  output logic               ce_n_o,
  output logic               oe_n_o,
  output logic [AW-1:0]      addr_o,
  output logic [7:0]         data_o
);
  logic [7:0] d_q;
  initial
  begin
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
    addr_o = '0;
    d_q    = 8'h00;
  end
  assign data_o = (!ce_n_o && oe_n_o) ? d_q : ~d_q;
  task automatic hold(input logic ce, input logic oe, input int n);
    @(posedge core_clk_i);
    ce_n_o <= ce;
    oe_n_o <= oe;
    repeat (n) @(posedge core_clk_i);
  endtask : hold
  task automatic read_byte(input logic [AW-1:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr_o <= a;
    hold(1'b1, 1'b0, 8);
    d = data_i;
    hold(1'b1, 1'b1, 6);
  endtask : read_byte
  task automatic prog_byte(input logic [AW-1:0] a, input logic [7:0] d);
    logic [7:0] rb;
    int tries;
    tries = 0;
    @(posedge core_clk_i);
    addr_o <= a;
    d_q    <= d;
    do
    begin
      tries++;
      hold(1'b0, 1'b1, 6);
      hold(1'b1, 1'b1, 6);
      read_byte(a, rb);
    end
    while (rb !== d && tries < 25);
    hold(1'b0, 1'b1, 6);
    hold(1'b1, 1'b1, 6);
  endtask : prog_byte
endmodule : prom_writer

// ---- tb_top.sv ----
// Purpose: self-checking bench for the memory decoder
// Assumes: small variant, 100 MHz clock
// Notes:   straps set per reset, then cpu and prom traffic
`timescale 1ns/10ps
module tb_top;
  import memdec_pkg::*;
  logic       core_clk_i = 1'b0;
  logic       reset_n_i  = 1'b0;
  logic [2:0] mode       = 3'b111;
  logic       standby_input_n_n     = 1'b1;
  logic [1:0] p6         = 2'b00;
  logic       ctl_wr     = 1'b0;
  logic [7:0] ctl_wd     = 8'hff;
  cpu_req_t   req        = '0;
  cpu_resp_t  resp;
  op_mode_t   op_mode;
  logic [7:0] ram_ctl, p_dout, w_data;
  logic [14:0] p_addr;
  logic       cpu_ready, mode_valid, rom_en, prom_mode, p_doe, p_ce_n, p_oe_n;
  int         failures = 0;
  int         n_checks = 0;
  wire logic [7:0] bus = p_doe ? p_dout : w_data;
  always #5 core_clk_i = ~core_clk_i;
  onchip_memory_decode_prom_port #(.LARGE_VARIANT(1'b0), .PROG_AW(15)) DUT (
    .core_clk_i           (core_clk_i),
    .reset_n_i            (reset_n_i),
    .mode_pin_2_i         (mode[2]),
    .mode_pin_1_i         (mode[1]),
    .mode_pin_0_i         (mode[0]),
    .standby_input_n_i    (standby_input_n_n),
    .port6_bit1_i         (p6[1]),
    .port6_bit0_i         (p6[0]),
    .prog_ce_n_i          (p_ce_n),
    .prog_oe_n_i          (p_oe_n),
    .prog_address_lines_i (p_addr),
    .prog_data_lines_i    (bus),
    .prog_data_lines_o    (p_dout),
    .prog_data_lines_oe_o (p_doe),
    .ram_ctl_wr_i         (ctl_wr),
    .ram_ctl_wdata_i      (ctl_wd),
    .ram_ctl_o            (ram_ctl),
    .cpu_req_i            (req),
    .cpu_ready_o          (cpu_ready),
    .cpu_resp_o           (resp),
    .mode_valid_o         (mode_valid),
    .op_mode_o            (op_mode),
    .rom_enabled_o        (rom_en),
    .prom_mode_o          (prom_mode)
  );
  prom_writer #(.AW(15)) wr (
    .core_clk_i (core_clk_i),
    .data_i     (bus),
    .ce_n_o     (p_ce_n),
    .oe_n_o     (p_oe_n),
    .addr_o     (p_addr),
    .data_o     (w_data)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic start(input logic [2:0] m, input logic sb, input logic [1:0] p);
    @(posedge core_clk_i);
    reset_n_i <= 1'b0;
    mode      <= m;
    standby_input_n_n    <= sb;
    p6        <= p;
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (5) @(posedge core_clk_i);
  endtask : start
  task automatic cpu(input logic wr_en, input logic [15:0] a, output cpu_resp_t r);
    @(posedge core_clk_i);
    req <= '{valid:1'b1, write:wr_en, fetch:1'b0, be:2'b11, addr:a, wdata:~a};
    @(negedge core_clk_i);
    for (int i = 0; i < 20 && cpu_ready !== 1'b1; i++) @(negedge core_clk_i);
    check(cpu_ready, 1'b1);
    @(posedge core_clk_i);
    req.valid <= 1'b0;
    repeat (2) @(negedge core_clk_i);
    r = resp;
  endtask : cpu
  task automatic ctl(input logic [7:0] d);
    @(posedge core_clk_i);
    ctl_wr <= 1'b1;
    ctl_wd <= d;
    @(posedge core_clk_i);
    ctl_wr <= 1'b0;
    @(negedge core_clk_i);
  endtask : ctl
  initial
  begin
    #100us;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    test_done;
  end
  initial
  begin
    cpu_resp_t r;
    logic [7:0] b;
    logic       re;
    static logic [2:0] ml [4] = '{3'b001, 3'b010, 3'b011, 3'b100};
    start(3'b111, 1'b1, 2'b00);
    check(ram_ctl, 8'hff);
    check({mode_valid, prom_mode}, 2'b10);
    cpu(1'b1, 16'hf680, r);
    cpu(1'b1, 16'hfe7e, r);
    cpu(1'b0, 16'hf680, r);
    check(r.rdata, 16'h097f);
    cpu(1'b0, 16'hfe7e, r);
    check({r.ram_hit, r.rdata}, {1'b1, 16'h0181});
    cpu(1'b0, 16'hfe80, r);
    check({r.ram_hit, r.ext_access}, 2'b01);
    check(r.addr, 16'hfe80);
    cpu(1'b1, 16'h7ffe, r);
    check(r.rom_hit, 1'b1);
    cpu(1'b0, 16'h8000, r);
    check({r.rom_hit, r.ext_access}, 2'b01);
    ctl(8'h00);
    check(ram_ctl, 8'h7f);
    cpu(1'b0, 16'hf680, r);
    check({r.addr_error, r.ram_hit}, 2'b10);
    @(posedge core_clk_i);
    mode <= 3'b001;
    cpu(1'b0, 16'h0100, r);
    check({op_mode, r.rom_hit}, {MODE_SINGLE, 1'b1});
    $display("test single-chip decode done");
    foreach (ml[i])
    begin
      start(ml[i], 1'b1, 2'b00);
      re = (ml[i] inside {3'b010, 3'b100});
      check(rom_en, re);
      cpu(1'b0, 16'h0100, r);
      check({r.rom_hit, r.ext_access}, {re, ~re});
      ctl(8'h00);
      cpu(1'b0, 16'hf680, r);
      check({r.ext_access, r.addr_error, r.ram_hit}, 3'b100);
    end
    $display("test expanded modes done");
    start(3'b000, 1'b0, 2'b11);
    check({prom_mode, cpu_ready}, 2'b10);
    wr.prog_byte(15'h0004, 8'h5a);
    wr.prog_byte(15'h0005, 8'hff);
    wr.read_byte(15'h0004, b);
    check(b, 8'h5a);
    check(p_doe, 1'b0);
    $display("test prom port done");
    start(3'b111, 1'b1, 2'b00);
    cpu(1'b0, 16'h0004, r);
    check(r.rdata, 16'hff5a);
    $display("test rom read-back done");
    test_done;
  end
endmodule : tb_top

// ---- word_store.sv ----
// Purpose: single-port word memory with byte enables and registered read data
// Assumes: one access per clock, read and write share the address
// Notes:   array itself has no reset
`timescale 1ns/10ps
module word_store #(
  parameter int DW    = 16,
  parameter int DEPTH = 1024,
  parameter int AW    = 10
)(
  // clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_n_i,
  // access port
  input  wire logic                 en_i,
  input  wire logic                 we_i,
  input  wire logic [DW/8-1:0]      be_i,
  input  wire logic [AW-1:0]        addr_i,
  input  wire logic [DW-1:0]        wdata_i,
  output logic      [DW-1:0]        rdata_o
);
  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] rdata_q;

  if (DW % 8 != 0 || (1 << AW) < DEPTH)
  begin : g_bad
    $error("word_store: bad width or depth");
  end

  always_ff @(posedge core_clk_i)
  begin
    if (en_i && we_i)
    begin
      for (int b = 0; b < DW/8; b++)
      begin
        if (be_i[b])
        begin
          mem_q[addr_i][b*8 +: 8] <= wdata_i[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_q <= '0;
    end
    else if (en_i)
    begin
      rdata_q <= mem_q[addr_i];
    end
  end

  assign rdata_o = rdata_q;
endmodule : word_store
